/* verilog/driver_buck_config_fault_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R01: Bit 30 of the configuration word turns driver delay compensation on when 1, off when 0.
// R02: Bits 29-26 give the target delay, 0 meaning automatic, 1 to F meaning 0.4 to 3.2 us in 0.2 us steps.
// R03: Bit 25 picks the regulator edge rate, 0 fast 1000 V/us, 1 slow 200 V/us.
// R04: Regulator sequencing runs only while bit 24 is 0, and that bit resets to 1.
// R05: Bits 22-21 pick 3.3, 5.0, 4.0 or 5.7 V and bit 23 picks a 600 mA or 150 mA limit.
// R06: The regulator runs while bit 20 is 0 and is turned off when it is written 1.
// R07: The configuration word sits at AEh, resets to 01200000h, and every bit is read/write.
// R08: Read-only fault words sit at E0h and E2h, and the gate-driver word reads all zero after reset.
// R09: Host software leaves other fault-status offsets alone and does not write them.
// R10: The gate-driver fault word carries its flags at the fixed bit positions of the layout.
// R11: The summary bit 31 is the OR of the individual gate-driver fault bits.
// R12: Bit 27 reads 0 once a supply power-on reset is seen and 1 when none is.
// R13: Writes to the fault words are ignored; only fault events, the fault clear or reset change flags.
module driver_buck_config_fault_regs
  import drv_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_b,
  // Register access port
  input  wire reg_req_t      i_reg_req,
  output logic      [31:0]   o_rd_data,
  output logic               o_rd_valid,
  // Fault sources
  input  wire fault_events_t i_fault_events,
  input  wire logic          i_fault_clear,
  input  wire logic [31:0]   i_controller_fault,
  // Configuration to the driver and regulator, and the fault summary
  output drv_cfg_t           o_cfg,
  output logic               o_driver_fault
);

  typedef struct packed {
    logic [31:0] config_two;
    logic [31:0] rd_data;
    logic        rd_valid;
    drv_cfg_t    cfg;
  } regs_state_t;

  regs_state_t               state_q;
  regs_state_t               state_d;
  logic [STICKY_WIDTH-1:0]   sticky_set;
  logic [STICKY_WIDTH-1:0]   sticky;
  logic [31:0]               fault_word;
  logic                      any_fault;
  logic                      cfg_write;

  // Named flags of the gate-driver fault word
  logic                      regulator_fault_flag;
  logic                      overcurrent_flag;
  logic                      supply_reset_seen_n;
  logic                      overvoltage_flag;
  logic                      overheat_flag;
  logic                      heat_warning_flag;
  logic                      heat_shutdown_flag;
  logic                      otp_error_flag;
  logic                      regulator_overcurrent_flag;
  logic                      regulator_undervoltage_flag;
  logic                      pump_undervoltage_flag;

  // Per-switch overcurrent, phase C high side first
  logic [STK_OVERVOLT-1:0]   switch_overcurrent;
  logic                      phase_c_high_overcurrent;
  logic                      phase_c_low_overcurrent;
  logic                      phase_b_high_overcurrent;
  logic                      phase_b_low_overcurrent;
  logic                      phase_a_high_overcurrent;
  logic                      phase_a_low_overcurrent;

  // Code 0 leaves the delay to the slew-rate logic, so no fixed figure
  function automatic logic [11:0] delay_ns_of(input logic [3:0] code);
    logic [11:0] ns;
    if (code == TARGET_DELAY_AUTO) begin
      ns = 12'h000;
    end else begin
      ns = 12'({8'h00, code} + 12'h001) * TARGET_STEP_NS;  // R02
    end
    return ns;
  endfunction : delay_ns_of

  // Output voltage in millivolts per select code
  function automatic logic [12:0] volt_mv_of(input logic [1:0] sel);
    logic [12:0] mv;
    case (sel)
      2'h0:    mv = VOLT_MV_CODE0;  // R05
      2'h1:    mv = VOLT_MV_CODE1;
      2'h2:    mv = VOLT_MV_CODE2;
      default: mv = VOLT_MV_CODE3;
    endcase
    return mv;
  endfunction : volt_mv_of

  // Field decode of a stored configuration word
  function automatic drv_cfg_t decode_cfg(input logic [31:0] word);
    drv_cfg_t c;
    c.parity                   = word[CFG_PARITY_BIT];
    c.delay_comp_en            = word[CFG_DELAY_COMP_BIT];  // R01
    c.target_delay_code        = word[CFG_TARGET_DELAY_HI:CFG_TARGET_DELAY_LO];
    c.target_delay_auto        = (c.target_delay_code == TARGET_DELAY_AUTO);  // R02
    c.target_delay_ns          = delay_ns_of(c.target_delay_code);  // R02
    c.regulator_edge_rate      = word[CFG_EDGE_RATE_BIT];  // R03
    c.regulator_sequencing_off = word[CFG_SEQ_OFF_BIT];
    c.regulator_sequencing_en  = ~word[CFG_SEQ_OFF_BIT];  // R04
    c.regulator_current_cap    = word[CFG_CURRENT_CAP_BIT];  // R05
    c.regulator_volt_sel       = word[CFG_VOLT_SEL_HI:CFG_VOLT_SEL_LO];
    c.regulator_volt_mv        = volt_mv_of(c.regulator_volt_sel);  // R05
    c.regulator_off            = word[CFG_REG_OFF_BIT];
    c.regulator_run            = ~word[CFG_REG_OFF_BIT];  // R06
    return c;
  endfunction : decode_cfg

  // Decoded reset word, so the reset branch loads a constant only
  localparam drv_cfg_t CFG_RESET = decode_cfg(CONFIG_TWO_RESET);  // R04

  assign sticky_set = {i_fault_events.supply_reset_event,
                       i_fault_events.pump_undervoltage_flag,
                       i_fault_events.regulator_undervoltage_flag,
                       i_fault_events.regulator_overcurrent_flag,
                       i_fault_events.otp_error,
                       i_fault_events.heat_shutdown_flag,
                       i_fault_events.heat_warning_flag,
                       i_fault_events.overvoltage_flag,
                       i_fault_events.switch_overcurrent};

  // Only fault events, the fault clear or reset touch the flags; bus writes never reach here
  fault_flag_bank #(
    .WIDTH   (STICKY_WIDTH),
    .RST_VAL (STICKY_RESET)
  ) u_flags (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_set      (sticky_set),
    .i_clear    (i_fault_clear),   // R13
    .o_flags    (sticky)
  );

  // Power-up counts as a supply reset, so bit 27 reads 0 until a clear
  assign supply_reset_seen_n         = ~sticky[STK_SUPPLY];  // R12
  assign {phase_c_high_overcurrent, phase_c_low_overcurrent,
          phase_b_high_overcurrent, phase_b_low_overcurrent,
          phase_a_high_overcurrent, phase_a_low_overcurrent} = sticky[STK_OVERVOLT-1:0];
  assign switch_overcurrent          = {phase_c_high_overcurrent, phase_c_low_overcurrent,
                                        phase_b_high_overcurrent, phase_b_low_overcurrent,
                                        phase_a_high_overcurrent, phase_a_low_overcurrent};
  assign overvoltage_flag            = sticky[STK_OVERVOLT];
  assign heat_warning_flag           = sticky[STK_HEAT_WARN];
  assign heat_shutdown_flag          = sticky[STK_HEAT_SHUT];
  assign otp_error_flag              = sticky[STK_OTP];
  assign regulator_overcurrent_flag  = sticky[STK_REG_OC];
  assign regulator_undervoltage_flag = sticky[STK_REG_UV];
  assign pump_undervoltage_flag      = sticky[STK_PUMP_UV];
  assign regulator_fault_flag        = regulator_overcurrent_flag | regulator_undervoltage_flag;
  assign overcurrent_flag            = |switch_overcurrent;
  assign overheat_flag               = heat_warning_flag | heat_shutdown_flag;

  // Only the configuration word decodes a write
  assign cfg_write = i_reg_req.wr && (i_reg_req.addr == ADDR_DRIVER_BUCK_CONFIG_TWO);  // R13

  // Summary leaves out the supply-reset bit so the word reads zero after reset
  assign any_fault = |sticky[STK_PUMP_UV:0];  // R11

  always_comb begin
    fault_word                                    = FAULT_WORD_RESET;
    fault_word[FLT_SUMMARY_BIT]                   = any_fault;  // R11
    fault_word[FLT_REGULATOR_BIT]                 = regulator_fault_flag;  // R10
    fault_word[FLT_OVERCUR_BIT]                   = overcurrent_flag;  // R10
    fault_word[FLT_SUPPLY_N_BIT]                  = supply_reset_seen_n;  // R12
    fault_word[FLT_OVERVOLT_BIT]                  = overvoltage_flag;  // R10
    fault_word[FLT_OVERHEAT_BIT]                  = overheat_flag;  // R10
    fault_word[FLT_HEAT_WARN_BIT]                 = heat_warning_flag;  // R10
    fault_word[FLT_HEAT_SHUT_BIT]                 = heat_shutdown_flag;  // R10
    fault_word[FLT_HEAT_SHUT_BIT-1:FLT_SWITCH_LO] = switch_overcurrent;  // R10
    fault_word[FLT_OTP_BIT]                       = otp_error_flag;  // R10
    fault_word[FLT_REG_OC_BIT]                    = regulator_overcurrent_flag;  // R10
    fault_word[FLT_REG_UV_BIT]                    = regulator_undervoltage_flag;  // R10
    fault_word[FLT_PUMP_UV_BIT]                   = pump_undervoltage_flag;  // R10
  end

  always_comb begin
    state_d          = state_q;
    state_d.rd_valid = i_reg_req.rd;
    if (cfg_write) begin
      state_d.config_two = i_reg_req.wdata;  // R07 R06
    end
    // Decode from the next word so fields change with the stored bits
    state_d.cfg = decode_cfg(state_d.config_two);  // R01 R02 R03 R05
    // A read in the write cycle still returns the old word
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        ADDR_DRIVER_BUCK_CONFIG_TWO: state_d.rd_data = state_q.config_two;  // R07
        ADDR_GATE_DRIVER_FAULT:      state_d.rd_data = fault_word;  // R08
        ADDR_CONTROLLER_FAULT:       state_d.rd_data = i_controller_fault;  // R08
        // Unmapped locations read zero
        default:                     state_d.rd_data = FAULT_WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q.config_two <= CONFIG_TWO_RESET;  // R07 R04
      state_q.rd_data    <= FAULT_WORD_RESET;
      state_q.rd_valid   <= 1'b0;
      state_q.cfg        <= CFG_RESET;  // R04
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rd_data      = state_q.rd_data;
  assign o_rd_valid     = state_q.rd_valid;
  assign o_driver_fault = any_fault;
  // Decoded fields come from flops, so the regulator never sees decode glitches
  assign o_cfg          = state_q.cfg;  // R01 R03 R05 R06

endmodule : driver_buck_config_fault_regs

`default_nettype wire

/* include/drv_cfg_pkg.sv */
package drv_cfg_pkg;

  // Register map
  localparam logic [7:0]  ADDR_DRIVER_BUCK_CONFIG_TWO = 8'hAE;
  localparam logic [7:0]  ADDR_GATE_DRIVER_FAULT      = 8'hE0;
  localparam logic [7:0]  ADDR_CONTROLLER_FAULT       = 8'hE2;
  localparam logic [31:0] CONFIG_TWO_RESET            = 32'h0120_0000;
  localparam logic [31:0] FAULT_WORD_RESET            = 32'h0000_0000;

  // Configuration word fields
  localparam int CFG_PARITY_BIT      = 31;
  localparam int CFG_DELAY_COMP_BIT  = 30;
  localparam int CFG_TARGET_DELAY_HI = 29;
  localparam int CFG_TARGET_DELAY_LO = 26;
  localparam int CFG_EDGE_RATE_BIT   = 25;
  localparam int CFG_SEQ_OFF_BIT     = 24;
  localparam int CFG_CURRENT_CAP_BIT = 23;
  localparam int CFG_VOLT_SEL_HI     = 22;
  localparam int CFG_VOLT_SEL_LO     = 21;
  localparam int CFG_REG_OFF_BIT     = 20;

  // Fault word fields
  localparam int FLT_SUMMARY_BIT   = 31;
  localparam int FLT_REGULATOR_BIT = 30;
  localparam int FLT_OVERCUR_BIT   = 28;
  localparam int FLT_SUPPLY_N_BIT  = 27;
  localparam int FLT_OVERVOLT_BIT  = 26;
  localparam int FLT_OVERHEAT_BIT  = 25;
  localparam int FLT_HEAT_WARN_BIT = 23;
  localparam int FLT_HEAT_SHUT_BIT = 22;
  localparam int FLT_SWITCH_LO     = 16;
  localparam int FLT_OTP_BIT       = 14;
  localparam int FLT_REG_OC_BIT    = 13;
  localparam int FLT_REG_UV_BIT    = 12;
  localparam int FLT_PUMP_UV_BIT   = 11;

  // Sticky flag vector layout
  localparam int STICKY_WIDTH  = 14;
  localparam int STK_OVERVOLT  = 6;
  localparam int STK_HEAT_WARN = 7;
  localparam int STK_HEAT_SHUT = 8;
  localparam int STK_OTP       = 9;
  localparam int STK_REG_OC    = 10;
  localparam int STK_REG_UV    = 11;
  localparam int STK_PUMP_UV   = 12;
  localparam int STK_SUPPLY    = 13;
  // Supply-reset flag starts set: a power-up is itself a reset event
  localparam logic [STICKY_WIDTH-1:0] STICKY_RESET = 14'h2000;

  // Target delay: code 0 automatic, else (code + 1) * step
  localparam logic [3:0]  TARGET_DELAY_AUTO = 4'h0;
  localparam logic [11:0] TARGET_STEP_NS    = 12'h0C8;

  // Regulator output voltage per code, in millivolts
  localparam logic [12:0] VOLT_MV_CODE0 = 13'h0CE4;
  localparam logic [12:0] VOLT_MV_CODE1 = 13'h1388;
  localparam logic [12:0] VOLT_MV_CODE2 = 13'h0FA0;
  localparam logic [12:0] VOLT_MV_CODE3 = 13'h1644;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] switch_overcurrent;  // [5] phase C high ... [0] phase A low
    logic       overvoltage_flag;
    logic       heat_warning_flag;
    logic       heat_shutdown_flag;
    logic       otp_error;
    logic       regulator_overcurrent_flag;
    logic       regulator_undervoltage_flag;
    logic       pump_undervoltage_flag;
    logic       supply_reset_event;
  } fault_events_t;

  typedef struct packed {
    logic        parity;
    logic        delay_comp_en;
    logic [3:0]  target_delay_code;
    logic        target_delay_auto;
    logic [11:0] target_delay_ns;
    logic        regulator_edge_rate;
    logic        regulator_sequencing_off;
    logic        regulator_sequencing_en;
    logic        regulator_current_cap;
    logic [1:0]  regulator_volt_sel;
    logic [12:0] regulator_volt_mv;
    logic        regulator_off;
    logic        regulator_run;
  } drv_cfg_t;

endpackage : drv_cfg_pkg

/* verilog/fault_flag_bank.sv */
`timescale 1ns/1ns
`default_nettype none

module fault_flag_bank
  import drv_cfg_pkg::*;
#(
  parameter int                       WIDTH   = STICKY_WIDTH,
  parameter logic [STICKY_WIDTH-1:0]  RST_VAL = STICKY_RESET
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  // Events and clear
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_clear,
  // Flags
  output logic      [WIDTH-1:0] o_flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;

  always_comb begin
    state_d = state_q;
    for (int i = 0; i < WIDTH; i++) begin
      // Set wins over a clear in the same cycle
      state_d.flags[i] = i_set[i] | (state_q.flags[i] & ~i_clear);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q.flags <= RST_VAL[WIDTH-1:0];
    end else begin
      state_q <= state_d;
    end
  end

  assign o_flags = state_q.flags;

endmodule : fault_flag_bank

`default_nettype wire

/* tb/cfg_regs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_regs_monitor
  import drv_cfg_pkg::*;
(
  // Clock and reset
  input wire logic          i_core_clk,
  input wire logic          i_rst_b,
  // Watched ports
  input wire reg_req_t      i_reg_req,
  input wire logic [31:0]   o_rd_data,
  input wire logic          o_rd_valid,
  input wire fault_events_t i_fault_events,
  input wire logic          i_fault_clear,
  input wire logic [31:0]   i_controller_fault,
  input wire drv_cfg_t      o_cfg,
  input wire logic          o_driver_fault
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic        cfg_wr = i_reg_req.wr && i_reg_req.addr == ADDR_DRIVER_BUCK_CONFIG_TWO;
  wire logic [11:0] cfg_f  = {o_cfg.parity, o_cfg.delay_comp_en, o_cfg.target_delay_code,
    o_cfg.regulator_edge_rate, o_cfg.regulator_sequencing_off, o_cfg.regulator_current_cap,
    o_cfg.regulator_volt_sel, o_cfg.regulator_off};
  AST_RD_VALID: assert property (1'b1 |=> o_rd_valid == $past(i_reg_req.rd))
    else $error("read answer pulse wrong");
  AST_E2_PASS: assert property (i_reg_req.rd && i_reg_req.addr == ADDR_CONTROLLER_FAULT
    |=> o_rd_data == $past(i_controller_fault)) else $error("controller word wrong");
  AST_CFG_WR: assert property (cfg_wr |=> cfg_f == $past(i_reg_req.wdata[31:20]))
    else $error("config write lost");
  AST_CFG_HOLD: assert property (!cfg_wr |=> $stable(cfg_f))
    else $error("config changed without write");
  AST_RUN_SEQ: assert property (o_cfg.regulator_run == !o_cfg.regulator_off
    && o_cfg.regulator_sequencing_en == !o_cfg.regulator_sequencing_off)
    else $error("regulator enables wrong");
  AST_DELAY: assert property (o_cfg.target_delay_ns == ((o_cfg.target_delay_code == 4'h0)
    ? 12'h000 : 12'({1'b0, o_cfg.target_delay_code} + 5'h01) * 12'h0C8))
    else $error("target delay wrong");
  AST_VOLT: assert property (o_cfg.regulator_volt_mv == (o_cfg.regulator_volt_sel[1]
    ? (o_cfg.regulator_volt_sel[0] ? 13'h1644 : 13'h0FA0)
    : (o_cfg.regulator_volt_sel[0] ? 13'h1388 : 13'h0CE4))) else $error("voltage wrong");
  AST_SUMMARY: assert property (|i_fault_events[13:1] |=> o_driver_fault)
    else $error("summary not raised");
  AST_E0_TOP: assert property (i_reg_req.rd && i_reg_req.addr == ADDR_GATE_DRIVER_FAULT
    |=> o_rd_data[31] == $past(o_driver_fault)) else $error("fault word bit 31 wrong");
  AST_RO: assert property (i_reg_req.wr && i_reg_req.addr == ADDR_GATE_DRIVER_FAULT
    && !i_fault_clear && i_fault_events == '0 |=> $stable(o_driver_fault))
    else $error("fault write took effect");
endmodule : cfg_regs_monitor
bind driver_buck_config_fault_regs cfg_regs_monitor i_mon (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_reg_req(i_reg_req), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .i_fault_events(i_fault_events), .i_fault_clear(i_fault_clear),
  .i_controller_fault(i_controller_fault), .o_cfg(o_cfg), .o_driver_fault(o_driver_fault));
`default_nettype wire

/* tb/host_port_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_port_model
  import drv_cfg_pkg::*;
(
  // Clock
  input  wire logic        i_core_clk,
  // Register access port
  output reg_req_t         o_reg_req,
  input  wire logic [31:0] i_rd_data,
  input  wire logic        i_rd_valid
);
  initial o_reg_req = '0;
  task automatic write_word(input logic [7:0] a, input logic [31:0] d);
    // Reserved fault-space offsets are never touched
    if (a >= 8'hE0 && a != ADDR_GATE_DRIVER_FAULT && a != ADDR_CONTROLLER_FAULT) return;
    @(negedge i_core_clk);
    o_reg_req = '{1'b0, 1'b1, a, d};
    @(negedge i_core_clk);
    o_reg_req = '0;
  endtask : write_word
  task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic ok);
    int n;
    @(negedge i_core_clk);
    o_reg_req = '{1'b1, 1'b0, a, 32'h0000_0000};
    @(negedge i_core_clk);
    o_reg_req = '0;
    n = 0;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(negedge i_core_clk);
      n++;
    end
    ok = (n < 4);
    d = i_rd_data;
  endtask : read_word
endmodule : host_port_model
`default_nettype wire

/* tb/tb_driver_buck_config_fault_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_driver_buck_config_fault_regs
  import drv_cfg_pkg::*;
;
  logic          i_core_clk = 1'b0;
  logic          i_rst_b = 1'b0;
  reg_req_t      req;
  logic [31:0]   rd_data;
  logic          rd_valid;
  fault_events_t ev = '0;
  logic          clr = 1'b0;
  logic [31:0]   ctl = 32'h5A5A_C3C3;
  drv_cfg_t      cfg;
  logic          drv_flt;
  int            fails = 0;
  int            check_count = 0;
  logic [31:0]   got;
  logic          ok;
  logic [31:0]   w;
  logic [31:0]   e;
  logic [31:0]   flt_tab [1:7] = '{32'h8800_0800, 32'hC800_1000, 32'hC800_2000,
    32'h8800_4000, 32'h8A40_0000, 32'h8A80_0000, 32'h8C00_0000};
  logic [12:0]   mv_tab [4] = '{13'h0CE4, 13'h1388, 13'h0FA0, 13'h1644};
  wire logic [4:0] cfg_bits = {cfg.delay_comp_en, cfg.regulator_edge_rate,
    cfg.regulator_current_cap, cfg.regulator_run, cfg.regulator_sequencing_en};
  always #5 i_core_clk = ~i_core_clk;
  host_port_model i_host (.i_core_clk(i_core_clk), .o_reg_req(req), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid));
  driver_buck_config_fault_regs i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_reg_req(req), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_fault_events(ev),
    .i_fault_clear(clr), .i_controller_fault(ctl), .o_cfg(cfg), .o_driver_fault(drv_flt));
  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_host.read_word(a, got, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("Error rd_valid expected 1 seen 0");
      close_out();
    end
    else chk("rd_data", exp, got);
  endtask : rd
  task automatic pulse(input logic [13:0] v, input logic c);
    @(negedge i_core_clk);
    ev = v;
    clr = c;
    @(negedge i_core_clk);
    ev = '0;
    clr = 1'b0;
  endtask : pulse
  initial begin
    repeat (12) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    rd(8'hAE, 32'h0120_0000);
    rd(8'hE0, 32'h0000_0000);
    rd(8'hE2, ctl);
    rd(8'h10, 32'h0000_0000);
    i_host.write_word(8'hE0, 32'hFFFF_FFFF);
    rd(8'hE0, 32'h0000_0000);
    $display("Test reset_map done");
    for (int k = 0; k < 16; k++) begin
      w = {k[0], k[1], k[3:0], k[2], k[3], k[0], k[1:0], k[1], 20'hA_5C3F};
      i_host.write_word(8'hAE, w);
      rd(8'hAE, w);
      chk("delay_ns", (k == 0) ? 32'h0 : 32'(k + 1) * 32'h0000_00C8, 32'(cfg.target_delay_ns));
      chk("volt_mv", 32'(mv_tab[k[1:0]]), 32'(cfg.regulator_volt_mv));
      chk("delay_auto", 32'(k == 0), 32'(cfg.target_delay_auto));
      chk("cfg_bits", 32'({k[1], k[2], k[0], !k[1], !k[3]}), 32'(cfg_bits));
    end
    $display("Test config done");
    for (int j = 0; j < 14; j++) begin
      pulse(14'h0000, 1'b1);
      pulse(14'h0001 << j, 1'b0);
      e = (j == 0) ? 32'h0 : (j < 8) ? flt_tab[j] : 32'h9800_0000 | (32'h1 << (j + 8));
      rd(8'hE0, e);
      chk("driver_fault", 32'(e[31]), 32'(drv_flt));
    end
    i_host.write_word(8'hE0, 32'h0000_0000);
    i_host.write_word(8'hE2, 32'h0000_0000);
    rd(8'hE0, 32'h9820_0000);
    rd(8'hE2, ctl);
    $display("Test faults done");
    close_out();
  end
endmodule : tb_driver_buck_config_fault_regs
`default_nettype wire
